// ### hw/ctx_continuous_tx.v
/*
 * continuous transmission test mode controller: apb register slave,
 * transceiver state sequencer, frame buffer and symbol byte stream.
 * assumes an apb master on sys_clk_in and an rf back end that takes
 * one byte per tx_byte_valid_out pulse plus a tone select.
 */
//
// Function
// R1: test mode transmits buffered frame or continuous wave without pause
// R2: offset tones select plus or minus 0.25 or 0.1 mhz settings
// R3: direct synthesizer tone at channel centre, no quadrature modulation
// R4: host loads phr then psdu; device then repeats psdu bytes continuously
// R5: host unmasks only the lock interrupt after reset
// R6: host forces the off state with command 0x03; code ignores it while in busy transmit
// R7: host sets channel and power, gain offset three for cw
// R8: status reads 0x08 while in the off state
// R9: command 0x09 starts synthesizer, lock sets interrupt status bit 0
// R10: command 0x02 starts transmission, state becomes busy transmit
// R11: host writes 0x00 to continuous tx register, then resets
// R12: phr length sets how many psdu bytes repeat each cycle
// R13: transmission continues until disable write or reset
`timescale 1ns/1ps
`include "ctx_regs.vh"

module ctx_continuous_tx #(
    parameter LOCK_CYCLES = `CTX_LOCK_CYCLES,
    parameter BUF_DEPTH   = 128
) (
    input  wire        sys_clk_in,
    input  wire        srst_in,
    input  wire        psel_in,
    input  wire        penable_in,
    input  wire        pwrite_in,
    input  wire [11:0] paddr_in,
    input  wire [31:0] pwdata_in,
    output wire [31:0] prdata_out,
    output wire        pready_out,
    output wire        pslverr_out,
    output reg  [7:0]  tx_byte_out,
    output reg         tx_byte_valid_out,
    output reg         tx_active_out,
    output reg  [1:0]  tone_sel_out,
    output reg         tone_direct_out,
    output reg         irq_out
);

    localparam ST_OFF  = 2'd0;
    localparam ST_LOCK = 2'd1;
    localparam ST_ON   = 2'd2;
    localparam ST_TX   = 2'd3;

    // ----------------------------------------------------------------
    // registers and state
    // ----------------------------------------------------------------
    reg  [7:0] irq_mask;
    reg  [7:0] irq_status;
    reg  [7:0] channel;
    reg  [7:0] tx_power;
    reg  [7:0] test_control;
    reg  [7:0] cont_tx;
    reg  [7:0] setup_36;
    reg  [7:0] frame_buf [0:BUF_DEPTH-1];
    reg  [1:0] state;
    reg  [7:0] lock_cnt;
    reg  [6:0] rd_ptr;
    reg  [7:0] rdata;
    reg        rd_err;
    reg  [7:0] state_code;

    wire       access   = psel_in & penable_in;
    wire       wr       = access & pwrite_in;
    wire [9:0] idx      = paddr_in[11:2];
    wire       buf_hit  = idx[9:7] == 3'b001;
    wire [6:0] buf_idx  = idx[6:0];
    wire [7:0] wbyte    = pwdata_in[7:0];
    wire [6:0] phr_len  = frame_buf[0][6:0];
    wire       cont_on  = cont_tx == `CTX_CONT_ENABLE;
    wire       is_cw    = test_control == `CTX_MODE_CW_100K
                        || test_control == `CTX_MODE_CW_250K
                        || test_control == `CTX_MODE_CW_DIRECT;

    assign pready_out  = 1'b1;
    assign prdata_out  = {24'h000000, rdata};
    assign pslverr_out = access & rd_err;

    // ----------------------------------------------------------------
    // read decode
    // ----------------------------------------------------------------
    always @* begin
        case (state)
            ST_OFF:  state_code = `CTX_STS_OFF; // [R8]
            ST_TX:   state_code = `CTX_STS_BUSY_TX; // [R10]
            default: state_code = `CTX_STS_SYNTH_ON;
        endcase
    end

    always @* begin
        rdata  = 8'h00;
        rd_err = 1'b0;
        if (buf_hit) begin
            rdata = frame_buf[buf_idx];
        end else if (idx[9:8] != 2'b00) begin
            rd_err = 1'b1;
        end else begin
            case (idx[7:0])
                `CTX_IDX_STATE_READBACK: rdata = state_code;
                `CTX_IDX_STATE_COMMAND:  rdata = state_code;
                `CTX_IDX_IRQ_MASK:       rdata = irq_mask;
                `CTX_IDX_IRQ_STATUS:     rdata = irq_status;
                `CTX_IDX_CHANNEL:        rdata = channel;
                `CTX_IDX_TX_POWER:       rdata = tx_power;
                `CTX_IDX_TEST_CONTROL:   rdata = test_control;
                `CTX_IDX_CONT_TX:        rdata = cont_tx;
                `CTX_IDX_TEST_SETUP_36:  rdata = setup_36;
                default:                 rd_err = 1'b1;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // frame buffer
    // ----------------------------------------------------------------
    always @(posedge sys_clk_in) begin
        if (wr && buf_hit) begin
            frame_buf[buf_idx] <= wbyte; // [R4]
        end
    end

    // ----------------------------------------------------------------
    // control registers, sequencer and stream
    // ----------------------------------------------------------------
    always @(posedge sys_clk_in) begin
        if (srst_in) begin
            irq_mask          <= 8'h00;
            irq_status        <= 8'h00;
            channel           <= 8'h00;
            tx_power          <= 8'h00;
            test_control      <= 8'h00;
            cont_tx           <= 8'h00;
            setup_36          <= 8'h00;
            state             <= ST_OFF;
            lock_cnt          <= 8'h00;
            rd_ptr            <= 7'h00;
            tx_byte_out       <= 8'h00;
            tx_byte_valid_out <= 1'b0;
            tx_active_out     <= 1'b0;
            tone_sel_out      <= 2'b00;
            tone_direct_out   <= 1'b0;
            irq_out           <= 1'b0;
        end else begin
            tx_byte_valid_out <= 1'b0;
            if (wr && !buf_hit && idx[9:8] == 2'b00) begin
                case (idx[7:0])
                    `CTX_IDX_IRQ_MASK:      irq_mask <= wbyte; // [R5]
                    `CTX_IDX_CHANNEL:       channel <= wbyte; // [R7]
                    `CTX_IDX_TX_POWER:      tx_power <= wbyte; // [R7]
                    `CTX_IDX_TEST_CONTROL:  test_control <= wbyte;
                    `CTX_IDX_CONT_TX:       cont_tx <= wbyte; // [R11]
                    `CTX_IDX_TEST_SETUP_36: setup_36 <= wbyte;
                    default:                ;
                endcase
            end
            // reading interrupt status clears it; a same-cycle lock wins
            if (access && !pwrite_in && !buf_hit
                    && idx[7:0] == `CTX_IDX_IRQ_STATUS) begin
                irq_status <= 8'h00;
            end
            case (state)
                ST_OFF: begin
                    lock_cnt <= 8'h00;
                    if (wr && !buf_hit && idx[7:0] == `CTX_IDX_STATE_COMMAND
                            && wbyte == `CTX_CMD_SYNTH_ON) begin
                        state <= ST_LOCK; // [R9]
                    end
                end
                ST_LOCK: begin
                    lock_cnt <= lock_cnt + 8'd1;
                    if (lock_cnt == LOCK_CYCLES[7:0] - 8'd1) begin
                        state <= ST_ON;
                        irq_status[`CTX_IRQ_LOCK_BIT] <= 1'b1; // [R9]
                    end
                end
                ST_ON: begin
                    if (wr && !buf_hit && idx[7:0] == `CTX_IDX_STATE_COMMAND
                            && wbyte == `CTX_CMD_TX_START) begin
                        state  <= ST_TX; // [R10]
                        rd_ptr <= 7'h00;
                    end
                end
                ST_TX: begin
                    if (!cont_on) begin
                        state <= ST_OFF; // [R13]
                    end else if (!is_cw) begin
                        // phr once, then psdu bytes 1..phr in a loop [R4]
                        tx_byte_valid_out <= 1'b1;
                        tx_byte_out       <= frame_buf[rd_ptr]; // [R1]
                        if (rd_ptr >= phr_len) begin
                            rd_ptr <= 7'h01; // [R12]
                        end else begin
                            rd_ptr <= rd_ptr + 7'h01;
                        end
                    end
                end
                default: state <= ST_OFF;
            endcase
            if (wr && !buf_hit && idx[7:0] == `CTX_IDX_STATE_COMMAND
                    && wbyte == `CTX_CMD_FORCE_OFF && state != ST_TX) begin
                state <= ST_OFF; // [R6]
            end
            tx_active_out   <= state == ST_TX && cont_on; // [R1] [R13]
            tone_direct_out <= test_control == `CTX_MODE_CW_DIRECT; // [R3]
            // bit1: 0.25 mhz setting, bit0: plus side from psdu byte [R2]
            tone_sel_out    <= {test_control == `CTX_MODE_CW_250K,
                                frame_buf[1][0]};
            irq_out         <= |(irq_status & irq_mask);
        end
    end

endmodule // ctx_continuous_tx

// ### hw/ctx_regs.vh
/*
 * register offsets, values and field positions of the continuous
 * transmission test mode controller; plain defines, no logic.
 */
`ifndef CTX_REGS_VH
`define CTX_REGS_VH

// ----------------------------------------------------------------
// register indices; the apb byte address is the index times four
// ----------------------------------------------------------------
`define CTX_IDX_STATE_READBACK  8'h01
`define CTX_IDX_STATE_COMMAND   8'h02
`define CTX_IDX_TEST_CONTROL    8'h0c
`define CTX_IDX_IRQ_MASK        8'h0e
`define CTX_IDX_IRQ_STATUS      8'h0f
`define CTX_IDX_CHANNEL         8'h08
`define CTX_IDX_TX_POWER        8'h05
`define CTX_IDX_CONT_TX         8'h1c
`define CTX_IDX_TEST_SETUP_36   8'h36
`define CTX_IDX_FRAME_BUF       8'h80
// ----------------------------------------------------------------
// state commands and readback codes
// ----------------------------------------------------------------
`define CTX_CMD_TX_START        8'h02
`define CTX_CMD_FORCE_OFF       8'h03
`define CTX_CMD_SYNTH_ON        8'h09
`define CTX_STS_OFF             8'h08
`define CTX_STS_SYNTH_ON        8'h09
`define CTX_STS_BUSY_TX         8'h02
`define CTX_CONT_DISABLE        8'h00
`define CTX_CONT_ENABLE         8'h46
// ----------------------------------------------------------------
// test control mode codes and interrupt bit
// ----------------------------------------------------------------
`define CTX_MODE_CW_100K        8'h0a
`define CTX_MODE_CW_250K        8'h0e
`define CTX_MODE_CW_DIRECT      8'h0f
`define CTX_IRQ_LOCK_BIT        0
`define CTX_GAIN_OFS_LSB        0
`define CTX_LOCK_CYCLES         8'd20
`define CTX_PHR_MAX             7'h7f

`endif

// ### tb/ctx_tx_monitor.sv
/* port checker for the continuous tx controller.
   assumes it is bound onto ctx_continuous_tx, one clock domain. */
`timescale 1ns/1ps
module ctx_tx_monitor (
    input wire        sys_clk_in,
    input wire        srst_in,
    input wire        psel_in,
    input wire        penable_in,
    input wire        pwrite_in,
    input wire [11:0] paddr_in,
    input wire [31:0] prdata_out,
    input wire        pslverr_out,
    input wire        tx_byte_valid_out,
    input wire        tx_active_out,
    input wire        tone_direct_out,
    input wire        irq_out
);
    logic wq1;
    logic wq2;
    wire  acc = psel_in && penable_in;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (srst_in);
    always_ff @(posedge sys_clk_in) begin
        wq1 <= acc && pwrite_in;
        wq2 <= wq1;
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    property p_quiet; $past(srst_in) |-> !tx_active_out && !irq_out; endproperty
    a_quiet: assert property (p_quiet) else $error("live after reset");
    property p_state; acc && !pwrite_in && paddr_in == 12'h004 |->
        prdata_out inside {32'h08, 32'h09, 32'h02}; endproperty
    a_state: assert property (p_state) else $error("bad state code");
    property p_map; acc && paddr_in inside {12'h004, 12'h008, 12'h038, 12'h070} |->
        !pslverr_out; endproperty
    a_map: assert property (p_map) else $error("error on mapped reg");
    property p_run; tx_byte_valid_out && tx_active_out |=>
        tx_byte_valid_out || !tx_active_out; endproperty
    a_run: assert property (p_run) else $error("stream paused");
    property p_valid; tx_byte_valid_out |-> tx_active_out || $past(tx_active_out); endproperty
    a_valid: assert property (p_valid) else $error("byte outside tx");
    property p_direct; tone_direct_out |-> !tx_byte_valid_out; endproperty
    a_direct: assert property (p_direct) else $error("direct tone modulated");
    property p_start; $rose(tx_active_out) |-> wq1 || wq2; endproperty
    a_start: assert property (p_start) else $error("tx began unasked");
    property p_stop; $fell(tx_active_out) && !$past(srst_in) |-> wq1 || wq2; endproperty
    a_stop: assert property (p_stop) else $error("tx ended unasked");
endmodule // ctx_tx_monitor

bind ctx_continuous_tx ctx_tx_monitor u_ctx_tx_monitor (.sys_clk_in(sys_clk_in),
    .srst_in(srst_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .prdata_out(prdata_out), .pslverr_out(pslverr_out),
    .tx_byte_valid_out(tx_byte_valid_out), .tx_active_out(tx_active_out),
    .tone_direct_out(tone_direct_out), .irq_out(irq_out));

// ### tb/ctx_host_model.sv
/* apb host that programs the controller registers.
   assumes a free running clock; the bench calls xfer. */
`timescale 1ns/1ps
module ctx_host_model (
    input  wire         sys_clk_in,
    input  wire         pready_in,
    input  wire  [31:0] prdata_in,
    input  wire         pslverr_in,
    output logic        psel_out = 1'b0,
    output logic        penable_out = 1'b0,
    output logic        pwrite_out = 1'b0,
    output logic [11:0] paddr_out = 12'h0,
    output logic [31:0] pwdata_out = 32'h0
);
    // one transfer; the bench orders them
    task xfer(input logic w, input logic [7:0] i, input logic [7:0] d,
              output logic [31:0] q, output logic err);
        @(posedge sys_clk_in);
        psel_out <= 1'b1;
        pwrite_out <= w;
        paddr_out <= {2'h0, i, 2'h0};
        pwdata_out <= {24'h0, d};
        @(posedge sys_clk_in);
        penable_out <= 1'b1;
        @(posedge sys_clk_in);
        while (pready_in !== 1'b1) @(posedge sys_clk_in);
        q = prdata_in;
        err = pslverr_in;
        psel_out <= 1'b0;
        penable_out <= 1'b0;
        paddr_out <= ~paddr_out;
        pwdata_out <= ~pwdata_out;
    endtask
endmodule // ctx_host_model

// ### tb/test_ctx_continuous_tx.sv
/* self-checking bench for the continuous tx controller.
   assumes the host model drives apb and lock time is shortened. */
`timescale 1ns/1ps
module test_ctx_continuous_tx;
    logic clk, srst = 1'b1, err, psel, pen, pwr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic pready, pslverr, tx_valid, tx_active, tone_direct, irq;
    logic [7:0] tx_byte, fb [4] = '{8'h03, 8'ha1, 8'hb2, 8'hc3}, md [3] = '{8'h0a, 8'h0e, 8'h0f};
    logic [1:0] tone_sel;
    int miscompares = 0, n_checks = 0, cycles = 0, k, got = 0;
    logic arm = 1'b0;
    logic [7:0] seen [8];
    ctx_continuous_tx #(.LOCK_CYCLES(4)) u_ctx_continuous_tx (.sys_clk_in(clk), .srst_in(srst),
        .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .tx_byte_out(tx_byte),
        .tx_byte_valid_out(tx_valid), .tx_active_out(tx_active), .tone_sel_out(tone_sel),
        .tone_direct_out(tone_direct), .irq_out(irq));
    ctx_host_model u_ctx_host_model (.sys_clk_in(clk), .pready_in(pready), .prdata_in(prdata),
        .pslverr_in(pslverr), .psel_out(psel), .penable_out(pen), .pwrite_out(pwr),
        .paddr_out(paddr), .pwdata_out(pwdata));
    initial begin clk = 1'b0; forever #2.5 clk = ~clk; end
    always @(posedge clk) if (arm && tx_valid === 1'b1 && got < 8) begin
        seen[got] <= tx_byte;
        got <= got + 1;
    end
    always @(posedge clk) if (++cycles == 20000) begin miscompares++; report_and_stop; end
    task report_and_stop;
        if (miscompares == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin miscompares++; $display("MISMATCH %s exp %h got %h", nm, e, g); end
    endtask
    task wr(input logic [7:0] i, input logic [7:0] d); u_ctx_host_model.xfer(1, i, d, q, err); endtask
    task rd(input string nm, input logic [7:0] i, input logic [31:0] e);
        u_ctx_host_model.xfer(0, i, 8'h0, q, err);
        chk(nm, e, q);
    endtask
    task start_tx;
        wr(8'h02, 8'h09);
        for (k = 0; k < 40 && irq !== 1'b1; k++) @(posedge clk);
        chk("irq", 1, irq);
        rd("irq_status", 8'h0f, 8'h01);
        rd("state", 8'h01, 8'h09);
        wr(8'h02, 8'h02);
        rd("state", 8'h01, 8'h02);
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        rd("state", 8'h01, 8'h08);
        rd("unmapped", 8'h3f, 0);
        chk("slverr", 1, err);
        wr(8'h0e, 8'h01);
        wr(8'h02, 8'h03);
        wr(8'h08, 8'h01);
        wr(8'h05, 8'h03);
        rd("mask", 8'h0e, 8'h01);
        rd("state", 8'h01, 8'h08);
        wr(8'h36, 8'h0f);
        wr(8'h0c, 8'h00);
        for (int i = 0; i < 4; i++) wr(8'h80 + i, fb[i]);
        wr(8'h1c, 8'h54);
        wr(8'h1c, 8'h46);
        arm = 1'b1;
        start_tx;
        for (k = 0; k < 100 && got < 8; k++) @(posedge clk);
        chk("count", 8, got);
        for (k = 0; k < 8; k++) chk("stream", fb[k < 1 ? 0 : 1 + (k - 1) % 3], seen[k]);
        wr(8'h02, 8'h03);
        rd("state", 8'h01, 8'h02);
        wr(8'h1c, 8'h00);
        rd("state", 8'h01, 8'h08);
        chk("active", 0, tx_active);
        for (int m = 0; m < 3; m++) begin
            wr(8'h0c, md[m]);
            wr(8'h81, m == 0 ? 8'h00 : 8'hff);
            wr(8'h1c, 8'h46);
            start_tx;
            chk("active", 1, tx_active);
            chk("direct", md[m] == 8'h0f, tone_direct);
            if (md[m] != 8'h0f) chk("tone", {md[m] == 8'h0e, m != 0}, tone_sel);
            chk("valid", 0, tx_valid);
            wr(8'h1c, 8'h00);
        end
        wr(8'h1c, 8'h46);
        start_tx;
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        rd("state", 8'h01, 8'h08);
        chk("active", 0, tx_active);
        report_and_stop;
    end
endmodule // test_ctx_continuous_tx
